// ---- rx_payload_output_port.sv ----
// receive payload output port: serial or nibble delivery of ds3 payload
// assumes a framer on the line clock marking overhead and frame start

// Summary of operation
// R01 - serial data changes on clock rising edge
// R02 - terminal samples serial data on rising edge
// R03 - terminal samples frame and marker alongside
// R04 - frame pulse marks first serial frame bit
// R05 - marker high during each overhead bit
// R06 - terminal drops bits flagged as overhead
// R07 - nibble data changes on clock falling edge; the code changes it in the low phase, NIB_SETUP_CYC cycles before the rise
// R08 - 1176 nibble clock pulses per frame
// R09 - nibble clock high about quarter period
// R10 - frame pulse spans first nibble period
// R11 - terminal samples nibble on rising edge
// R12 - terminal samples frame with each nibble
// R13 - no overhead in nibble mode, marker low
// R14 - mode select high picks nibble mode
// R15 - serial clock follows 44.736 MHz line
// R16 - serial frame pulse lasts one bit
// R17 - earliest bit on nibble msb line
module rx_payload_output_port import rx_payload_pkg::*; (
	// core clock and reset
	input  wire logic       clock,
	input  wire logic       rst_b,
	// line clock domain from the framer
	input  wire logic       lineReceiveClock,
	input  wire logic       rxBit,
	input  wire logic       rxOverhead,
	input  wire logic       rxFrameFirst,
	// mode strap
	input  wire logic       nibbleModeSelect,
	// terminal equipment side
	output logic            payloadOutClock,
	output logic            serialPayloadOut,
	output logic [3:0]      nibblePayloadOut,
	output logic            frameStartPulse,
	output logic            overheadBitMarker
);

	// ****************************************************
	// line side capture
	// ****************************************************
	rx_link_if linkBus ();     // crossing bundle

	rx_link_capture linkCapture (
		.lineReceiveClock (lineReceiveClock),
		.rst_b            (rst_b),
		.rxBit            (rxBit),
		.rxOverhead       (rxOverhead),
		.rxFrameFirst     (rxFrameFirst),
		.linkOut          (linkBus)
	);

	// ****************************************************
	// crossing and mode synchronisers
	// ****************************************************
	logic toggleMeta;          // first stage, read only by toggleSync
	logic toggleSync;          // synchronised toggle
	logic toggleSeen;          // last toggle acted upon
	logic modeMeta;            // first stage, read only by modeNibble
	logic modeNibble;          // synchronised mode select
	logic modePrev;            // mode one cycle ago
	logic newBit;              // one core cycle per line bit
	logic modeChange;          // mode select moved

	// two flops each for the toggle and the mode select
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			toggleMeta <= 1'b0;
			toggleSync <= 1'b0;
			toggleSeen <= 1'b0;
			modeMeta   <= 1'b0;
			modeNibble <= 1'b0;
			modePrev   <= 1'b0;
		end else begin
			toggleMeta <= linkBus.toggle;
			toggleSync <= toggleMeta;
			toggleSeen <= toggleSync;
			modeMeta   <= nibbleModeSelect;
			modeNibble <= modeMeta;
			modePrev   <= modeNibble;
		end
	end

	// holding register is stable here, two or three core cycles after its write
	assign newBit     = toggleSync ^ toggleSeen;
	assign modeChange = modeNibble ^ modePrev;

	// ****************************************************
	// nibble assembly
	// ****************************************************
	logic [2:0] shiftBits;     // earlier payload bits of the nibble
	logic [1:0] bitCount;      // payload bits gathered so far
	logic       pendingFirst;  // next nibble opens a frame
	logic       nibLoad;       // a full nibble is ready
	logic       nibFirst;      // that nibble opens a frame
	logic [3:0] next_nibble;   // nibble about to be presented

	// completes on the fourth payload bit; overhead never counts
	always_comb begin
		nibLoad     = 1'b0;
		nibFirst    = pendingFirst | linkBus.firstFlag;
		next_nibble = {shiftBits, linkBus.bitData};
		if (newBit && modeNibble && !modeChange && !linkBus.ohFlag) begin
			if (linkBus.firstFlag) begin
				nibLoad = 1'b0;
			end else begin
				nibLoad = (bitCount == 2'(NIB_BITS - 1));
			end
		end
	end

	// gather payload bits, restarting at each frame boundary
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			shiftBits    <= 3'h0;
			bitCount     <= BITCNT_RESET;
			pendingFirst <= 1'b0;
		end else if (modeChange || !modeNibble) begin
			shiftBits    <= 3'h0;
			bitCount     <= BITCNT_RESET;
			pendingFirst <= 1'b0;
		end else if (newBit) begin
			// R13 overhead bits dropped
			if (linkBus.firstFlag) begin
				shiftBits    <= {2'h0, linkBus.bitData};
				bitCount     <= linkBus.ohFlag ? 2'h0 : 2'h1;
				pendingFirst <= 1'b1;
			end else if (!linkBus.ohFlag) begin
				// R17 earliest bit shifts toward msb
				shiftBits    <= {shiftBits[1:0], linkBus.bitData};
				bitCount     <= bitCount + 2'h1;
				if (nibLoad) begin
					pendingFirst <= 1'b0;
				end
			end
		end
	end

	// ****************************************************
	// payload clock generator
	// ****************************************************
	nib_state_t           nibState;   // nibble clock phase
	logic [PHASE_W-1:0]   phaseCount; // cycles left in a phase

	// serial: rise with each bit; nibble: low setup, then short high
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			payloadOutClock <= 1'b0;
			phaseCount      <= '0;
			nibState        <= NIB_IDLE;
		end else if (modeChange) begin
			payloadOutClock <= 1'b0;
			phaseCount      <= '0;
			nibState        <= NIB_IDLE;
		end else if (!modeNibble) begin
			nibState <= NIB_IDLE;
			if (newBit) begin
				// R01 R15 rising edge per line bit
				payloadOutClock <= 1'b1;
				phaseCount      <= PHASE_W'(SER_HIGH_CYC - 1);
			end else if (phaseCount != '0) begin
				phaseCount <= phaseCount - PHASE_W'(1);
			end else begin
				payloadOutClock <= 1'b0;
			end
		end else begin
			case (nibState)
				NIB_IDLE: begin
					payloadOutClock <= 1'b0;
					// R08 one clock pulse per nibble
					if (nibLoad) begin
						nibState   <= NIB_SETUP;
						phaseCount <= PHASE_W'(NIB_SETUP_CYC - 1);
					end
				end
				NIB_SETUP: begin
					if (phaseCount != '0) begin
						phaseCount <= phaseCount - PHASE_W'(1);
					end else begin
						// R09 quarter duty high phase
						payloadOutClock <= 1'b1;
						phaseCount      <= PHASE_W'(NIB_HIGH_CYC - 1);
						nibState        <= NIB_HIGH;
					end
				end
				NIB_HIGH: begin
					if (phaseCount != '0) begin
						phaseCount <= phaseCount - PHASE_W'(1);
					end else begin
						payloadOutClock <= 1'b0;
						nibState        <= NIB_IDLE;
					end
				end
				default: begin
					payloadOutClock <= 1'b0;
					nibState        <= NIB_IDLE;
				end
			endcase
		end
	end

	// ****************************************************
	// data and indicator outputs
	// ****************************************************
	// serial lines update with the clock rise, nibble lines while low
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			serialPayloadOut  <= 1'b0;
			nibblePayloadOut  <= NIBBLE_RESET;
			frameStartPulse   <= 1'b0;
			overheadBitMarker <= 1'b0;
		end else if (modeChange) begin
			serialPayloadOut  <= 1'b0;
			nibblePayloadOut  <= NIBBLE_RESET;
			frameStartPulse   <= 1'b0;
			overheadBitMarker <= 1'b0;
		end else if (!modeNibble) begin
			// R14 nibble lines idle in serial mode
			nibblePayloadOut <= NIBBLE_RESET;
			if (newBit) begin
				// R04 R16 frame pulse for one bit
				serialPayloadOut  <= linkBus.bitData;
				frameStartPulse   <= linkBus.firstFlag;
				// R05 marker tracks overhead bits
				overheadBitMarker <= linkBus.ohFlag;
			end
		end else begin
			// R13 marker and serial line idle
			serialPayloadOut  <= 1'b0;
			overheadBitMarker <= 1'b0;
			if (nibLoad) begin
				// R07 R10 update during the low phase
				nibblePayloadOut <= next_nibble;
				frameStartPulse  <= nibFirst;
			end
		end
	end

	// ****************************************************
	// checks
	// ****************************************************
	logic [PULSE_CNT_W-1:0] pulseTally;  // nibble pulses this frame
	logic                   tallyValid;  // a full frame is counted

	// counts nibble clock rises between frame openings
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pulseTally <= '0;
			tallyValid <= 1'b0;
		end else if (!modeNibble || modeChange) begin
			pulseTally <= '0;
			tallyValid <= 1'b0;
		end else if (nibLoad && nibFirst) begin
			pulseTally <= '0;
			tallyValid <= 1'b1;
		end else if (nibState == NIB_SETUP && phaseCount == '0) begin
			pulseTally <= pulseTally + PULSE_CNT_W'(1);
		end
	end

	sequence serialBit;
		newBit && !modeNibble && !modeChange;
	endsequence

	sequence nibRise;
		$rose(payloadOutClock) && modeNibble && modePrev;
	endsequence

	a_serial_data_edge: assert property ( // R01
		@(posedge clock) disable iff (!rst_b)
		serialBit |=> $rose(payloadOutClock)
			&& serialPayloadOut == $past(linkBus.bitData))
		else $error("serial data not launched with clock rise");

	a_serial_clk_high: assert property ( // R15
		@(posedge clock) disable iff (!rst_b)
		$rose(payloadOutClock) && !modeNibble && !modePrev
			|-> payloadOutClock[*2] ##1 !payloadOutClock)
		else $error("serial clock high time wrong");

	a_serial_frame_bit: assert property ( // R04
		@(posedge clock) disable iff (!rst_b)
		serialBit |=> frameStartPulse == $past(linkBus.firstFlag))
		else $error("frame pulse not on first frame bit");

	a_overhead_marker: assert property ( // R05
		@(posedge clock) disable iff (!rst_b)
		serialBit |=> overheadBitMarker == $past(linkBus.ohFlag))
		else $error("overhead marker does not follow bit");

	a_nibble_fall_update: assert property ( // R07
		@(posedge clock) disable iff (!rst_b)
		modeNibble && modePrev && $changed(nibblePayloadOut)
			|-> (!payloadOutClock)[*5])
		else $error("nibble changed near clock high");

	a_nibble_duty: assert property ( // R09
		@(posedge clock) disable iff (!rst_b)
		nibRise |-> payloadOutClock[*5] ##1 !payloadOutClock)
		else $error("nibble clock high time wrong");

	a_nibble_pulse_count: assert property ( // R08
		@(posedge clock) disable iff (!rst_b)
		nibLoad && nibFirst && tallyValid
			|-> pulseTally == PULSE_CNT_W'(NIBBLES_PER_FRAME))
		else $error("wrong nibble pulse count per frame");

	a_nibble_frame_flag: assert property ( // R10
		@(posedge clock) disable iff (!rst_b)
		nibLoad && nibFirst && modeNibble |=> frameStartPulse
			&& nibblePayloadOut == $past(next_nibble))
		else $error("frame flag missing on first nibble");

	a_nibble_no_marker: assert property ( // R13
		@(posedge clock) disable iff (!rst_b)
		modeNibble && modePrev |-> !overheadBitMarker && !serialPayloadOut)
		else $error("marker or serial active in nibble mode");

	a_serial_idle_nibble: assert property ( // R14
		@(posedge clock) disable iff (!rst_b)
		!modeNibble && !modePrev |-> nibblePayloadOut == NIBBLE_RESET)
		else $error("nibble lines active in serial mode");

endmodule : rx_payload_output_port

// ---- rx_payload_pkg.sv ----
// constants and types shared by the receive payload output port
// assumes a 250 MHz core clock and a ds3 line clock near 44.736 MHz
package rx_payload_pkg;

	// ****************************************************
	// timing
	// ****************************************************
	// core clock period in picoseconds
	localparam int SYS_PERIOD_PS  = 4000;
	// ds3 line period, 44.736 MHz, in picoseconds
	localparam int LINE_PERIOD_PS = 22353;
	// serial clock high time, half a line period, rounded down
	localparam int SER_HIGH_CYC   = (LINE_PERIOD_PS / 2) / SYS_PERIOD_PS;
	// nibble clock high time, a quarter of four bit periods
	localparam int NIB_HIGH_CYC   = LINE_PERIOD_PS / SYS_PERIOD_PS;
	// nibble data setup before the rising clock edge
	localparam int NIB_SETUP_CYC  = LINE_PERIOD_PS / SYS_PERIOD_PS;
	// width of the phase counter
	localparam int PHASE_W        = 4;

	// ****************************************************
	// framing
	// ****************************************************
	// nibble clock pulses per inbound ds3 frame
	localparam int NIBBLES_PER_FRAME = 1176;
	// bits per nibble
	localparam int NIB_BITS          = 4;
	// pulse counter width
	localparam int PULSE_CNT_W       = 11;

	// ****************************************************
	// reset values
	// ****************************************************
	localparam logic [3:0] NIBBLE_RESET = 4'h0;
	localparam logic [1:0] BITCNT_RESET = 2'h0;

	// nibble clock sequencer states
	typedef enum logic [1:0] {
		NIB_IDLE  = 2'b00,
		NIB_SETUP = 2'b01,
		NIB_HIGH  = 2'b10
	} nib_state_t;

endpackage : rx_payload_pkg

// ---- rx_link_if.sv ----
// bundle carrying one received line bit from the line clock domain
// assumes the writer holds the fields stable around each toggle
interface rx_link_if;

	logic bitData;   // received bit
	logic ohFlag;    // bit is framing overhead
	logic firstFlag; // bit is the first of a ds3 frame
	logic toggle;    // flips once per new bit

	// line clock side
	modport link (
		output bitData,
		output ohFlag,
		output firstFlag,
		output toggle
	);

	// core clock side
	modport core (
		input bitData,
		input ohFlag,
		input firstFlag,
		input toggle
	);

endinterface : rx_link_if

// ---- rx_link_capture.sv ----
// line clock side capture of the received bit stream
// assumes the framer presents one bit per rising line clock edge
module rx_link_capture (
	// line clock domain
	input  wire logic lineReceiveClock,
	input  wire logic rst_b,
	// framer bit stream
	input  wire logic rxBit,
	input  wire logic rxOverhead,
	input  wire logic rxFrameFirst,
	// towards the core domain
	rx_link_if.link   linkOut
);

	// ****************************************************
	// holding register
	// ****************************************************
	// captured once per line bit, stable for a full line period
	always_ff @(posedge lineReceiveClock or negedge rst_b) begin
		if (!rst_b) begin
			linkOut.bitData   <= 1'b0;
			linkOut.ohFlag    <= 1'b0;
			linkOut.firstFlag <= 1'b0;
		end else begin
			linkOut.bitData   <= rxBit;
			linkOut.ohFlag    <= rxOverhead;
			linkOut.firstFlag <= rxFrameFirst;
		end
	end

	// ****************************************************
	// event toggle
	// ****************************************************
	// one flip per bit; the core side detects the change
	always_ff @(posedge lineReceiveClock or negedge rst_b) begin
		if (!rst_b) begin
			linkOut.toggle <= 1'b0;
		end else begin
			linkOut.toggle <= ~linkOut.toggle;
		end
	end

endmodule : rx_link_capture

// ---- rx_terminal_model.sv ----
// terminal equipment model consuming the receive payload port outputs
// assumes it shares the core clock and that the bench tells it the mode
module rx_terminal_model (
	// core clock and reset
	input  wire logic       clock,
	input  wire logic       rst_b,
	// payload port outputs
	input  wire logic       payloadOutClock,
	input  wire logic       serialPayloadOut,
	input  wire logic [3:0] nibblePayloadOut,
	input  wire logic       frameStartPulse,
	input  wire logic       overheadBitMarker,
	// mode the bench selected
	input  wire logic       nibbleMode
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       prevClk;    // payload clock one cycle ago
	logic [6:0] prevOut;    // outputs one cycle ago
	logic [6:0] cur;        // outputs this cycle
	logic       rise;       // payload clock rising now
	logic       inFrame;    // a frame start was captured
	int         frames;     // frame starts captured
	int         pulses;     // clock pulses in current frame
	int         perFrame;   // pulses of last whole frame
	int         ohBits;     // bits dropped as overhead
	int         highRun;    // cycles of current high phase
	int         lastHigh;   // length of last high phase
	int         edgeFaults; // output moved off its edge
	int         markFaults; // idle output or marker active
	logic       payload[$]; // payload bits in arrival order

	// forget frames, counts, faults and payload seen so far
	function automatic void clear();
		inFrame = 1'b0;
		frames = 0;
		pulses = 0;
		perFrame = 0;
		ohBits = 0;
		edgeFaults = 0;
		markFaults = 0;
		payload.delete();
	endfunction : clear

	// ****************************************************
	// sampling at the payload clock
	// ****************************************************
	// core clock view of the terminal pins
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			prevClk = 1'b0;
			prevOut = 7'h00;
			highRun = 0;
		end else begin
			cur = {serialPayloadOut, nibblePayloadOut,
				frameStartPulse, overheadBitMarker};
			rise = payloadOutClock && !prevClk;
			// edge discipline of both modes
			if (!nibbleMode && !rise &&
				{cur[6], cur[1:0]} !== {prevOut[6], prevOut[1:0]})
				edgeFaults++;
			if (nibbleMode && payloadOutClock && cur[5:2] !== prevOut[5:2])
				edgeFaults++;
			// unused outputs stay quiet
			if (nibbleMode && (overheadBitMarker || serialPayloadOut))
				markFaults++;
			if (!nibbleMode && nibblePayloadOut !== 4'h0)
				markFaults++;
			// high phase length
			if (payloadOutClock) begin
				highRun++;
			end else if (prevClk) begin
				lastHigh = highRun;
				highRun = 0;
			end
			if (rise) begin
				if (frameStartPulse) begin
					if (inFrame)
						perFrame = pulses;
					inFrame = 1'b1;
					frames++;
					pulses = 0;
				end
				if (inFrame) begin
					pulses++;
					if (nibbleMode) begin
						for (int b = 3; b >= 0; b--) begin
							payload.push_back(nibblePayloadOut[b]);
						end
					end else if (overheadBitMarker) begin
						ohBits++;
					end else begin
						payload.push_back(serialPayloadOut);
					end
				end
			end
			prevClk = payloadOutClock;
			prevOut = cur;
		end
	end

endmodule : rx_terminal_model

// ---- rx_payload_output_port_bench.sv ----
// bench for the receive payload port: framer stream in, terminal model out
// assumes a 4 ns core clock and a free 48 ns line clock
module rx_payload_output_port_bench import rx_payload_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

`define CHECK(what, exp, got) \
	checks++; \
	if ((got) !== (exp)) begin \
		failCount++; \
		$display("Error %s expected %0h seen %0h", what, exp, got); \
	end

	logic       clock;             // core clock
	logic       rst_b;             // reset, active low
	logic       lineReceiveClock;  // line clock
	logic       rxBit;             // line bit
	logic       rxOverhead;        // line bit is overhead
	logic       rxFrameFirst;      // line bit starts a frame
	logic       nibbleModeSelect;  // mode pin
	logic       payloadOutClock;   // port outputs
	logic       serialPayloadOut;
	logic [3:0] nibblePayloadOut;
	logic       frameStartPulse;
	logic       overheadBitMarker;
	int         lineIdx;           // bit index in frame
	logic       restartPending;    // start a frame at next bit
	int         failCount;         // mismatches
	int         checks;            // comparisons

	rx_payload_output_port uut (
		.clock(clock), .rst_b(rst_b), .lineReceiveClock(lineReceiveClock),
		.rxBit(rxBit), .rxOverhead(rxOverhead), .rxFrameFirst(rxFrameFirst),
		.nibbleModeSelect(nibbleModeSelect),
		.payloadOutClock(payloadOutClock), .serialPayloadOut(serialPayloadOut),
		.nibblePayloadOut(nibblePayloadOut), .frameStartPulse(frameStartPulse),
		.overheadBitMarker(overheadBitMarker));

	rx_terminal_model term (
		.clock(clock), .rst_b(rst_b), .payloadOutClock(payloadOutClock),
		.serialPayloadOut(serialPayloadOut), .nibblePayloadOut(nibblePayloadOut),
		.frameStartPulse(frameStartPulse), .overheadBitMarker(overheadBitMarker),
		.nibbleMode(nibbleModeSelect));

	// ****************************************************
	// clocks and framer stream
	// ****************************************************
	// core clock, rising edges on even times
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// line clock, rising edges on odd times
	initial begin
		lineReceiveClock = 1'b0;
		#1 lineReceiveClock = 1'b1;
		forever #24 lineReceiveClock = ~lineReceiveClock;
	end

	// payload pattern of a line bit
	function automatic logic pat(input int i);
		return i[0] ^ i[2] ^ i[5] ^ i[9];
	endfunction : pat

	// k-th payload bit, one overhead bit per 85
	function automatic logic expBit(input int k);
		return pat(k + k / 84 + 1);
	endfunction : expBit

	// framer: 4760 bit frames, overhead at each 85th bit
	always @(posedge lineReceiveClock) begin
		if (!rst_b) begin
			lineIdx = 0;
			rxBit <= 1'b0;
			rxOverhead <= 1'b0;
			rxFrameFirst <= 1'b0;
		end else begin
			if (restartPending) begin
				lineIdx = 0;
				restartPending = 1'b0;
			end
			rxBit <= pat(lineIdx);
			rxOverhead <= (lineIdx % 85 == 0);
			rxFrameFirst <= (lineIdx == 0);
			lineIdx = (lineIdx + 1) % 4760;
		end
	end

	// ****************************************************
	// scenarios
	// ****************************************************
	// select a mode, let it settle, restart the frame
	task automatic startFrame(input logic mode);
		@(posedge clock);
		nibbleModeSelect <= mode;
		repeat (8) @(posedge clock);
		restartPending = 1'b1;
		// let older frame marks drain before the model forgets
		wait (!restartPending);
		repeat (6) @(posedge clock);
		@(negedge clock);
		term.clear();
	endtask : startFrame

	// serial delivery of the head of a frame
	task automatic serialFrame();
		int total;
		startFrame(1'b0);
		for (int n = 0; n < 20000 && term.payload.size() < 300; n++) begin
			@(posedge clock);
		end
		@(negedge clock);
		total = term.payload.size() + term.ohBits;
		for (int k = 0; k < 300; k++) begin
			`CHECK("serial bit", expBit(k), term.payload[k])
		end
		`CHECK("overhead bits", (total - 1) / 85 + 1, term.ohBits)
		`CHECK("serial frames", 1, term.frames)
		`CHECK("serial edges", 0, term.edgeFaults)
		`CHECK("serial idle nibble", 0, term.markFaults)
		`CHECK("serial high time", SER_HIGH_CYC, term.lastHigh)
	endtask : serialFrame

	// one whole frame in nibble mode
	task automatic nibbleFrames();
		startFrame(1'b1);
		for (int n = 0; n < 70000 && term.frames < 2; n++) begin
			@(posedge clock);
		end
		@(negedge clock);
		`CHECK("pulses per frame", NIBBLES_PER_FRAME, term.perFrame)
		`CHECK("nibble frames", 2, term.frames)
		`CHECK("nibble high time", NIB_HIGH_CYC, term.lastHigh)
		`CHECK("nibble edges", 0, term.edgeFaults)
		`CHECK("nibble marker", 0, term.markFaults)
		for (int k = 0; k < 4704; k++) begin
			`CHECK("nibble bit", expBit(k), term.payload[k])
		end
	endtask : nibbleFrames

	// reset during nibble traffic quiets every output
	task automatic resetMidRun();
		logic [7:0] outs;
		@(posedge clock);
		rst_b <= 1'b0;
		// held past a full line period so the framer restarts too
		repeat (13) @(posedge clock);
		outs = {payloadOutClock, serialPayloadOut, nibblePayloadOut,
			frameStartPulse, overheadBitMarker};
		`CHECK("outputs in reset", 8'h00, outs)
		rst_b <= 1'b1;
		@(posedge clock);
		@(negedge clock);
		outs = {payloadOutClock, serialPayloadOut, nibblePayloadOut,
			frameStartPulse, overheadBitMarker};
		`CHECK("outputs after reset", 8'h00, outs)
	endtask : resetMidRun

	// ****************************************************
	// verdict, watchdog and main sequence
	// ****************************************************
	task automatic results();
		if (failCount == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	// cut a hang short well after the expected 65k cycles
	initial begin
		repeat (90000) @(posedge clock);
		failCount++;
		results();
	end

	// main sequence
	initial begin
		rst_b = 1'b0;
		nibbleModeSelect = 1'b0;
		rxBit = 1'b0;
		rxOverhead = 1'b0;
		rxFrameFirst = 1'b0;
		restartPending = 1'b0;
		failCount = 0;
		checks = 0;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		serialFrame();
		nibbleFrames();
		resetMidRun();
		serialFrame();
		results();
	end

endmodule : rx_payload_output_port_bench
